// File: src/sfcs_pkg.sv
package sfcs_pkg;
    // Link timing
    localparam int CLK_NS       = 5;
    localparam int SCK_HALF_NS  = 40;
    localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
    // Flash opcodes
    localparam logic [7:0] OPC_ID    = 8'h9f;
    localparam logic [7:0] OPC_STAT  = 8'h05;
    localparam logic [7:0] OPC_WREN  = 8'h06;
    localparam logic [7:0] OPC_CE    = 8'hc7;
    localparam logic [7:0] OPC_RD    = 8'h03;
    localparam logic [7:0] OPC_PP    = 8'h02;
    localparam logic [7:0] OPC_SE    = 8'h20;
    localparam logic [7:0] OPC_PARAM = 8'h5a;
    // Status bits
    localparam int ST_BUSY = 0;
    localparam int ST_WEL  = 1;
    // Frame shapes: bytes ahead of data, data counts
    localparam logic [2:0]  HDR_OPC   = 3'h1;
    localparam logic [2:0]  HDR_ADDR  = 3'h4;
    localparam logic [2:0]  HDR_PARAM = 3'h5;
    localparam logic [15:0] ID_LEN    = 16'h0003;
    localparam logic [15:0] STAT_LEN  = 16'h0001;
    localparam logic [15:0] PP_MAX    = 16'h00ff;
    // Sector and file store
    localparam logic [23:0] SECT_MASK  = 24'hfff000;
    localparam int          BLK_LOG2   = 12;
    localparam logic [25:0] BLK_ROUND  = 26'h0000fff;
    localparam logic [24:0] FILE_MAX   = 25'h1000000;
    localparam logic [7:0]  FILES_MAX  = 8'h80;
    localparam logic [23:0] STORE_BASE = 24'h000000;

    typedef enum logic [2:0] {
        OP_ID = 3'h0, OP_STAT = 3'h1, OP_RD = 3'h2, OP_PARAM = 3'h3,
        OP_PP = 3'h4, OP_SE = 3'h5, OP_CE = 3'h6
    } sfcs_op_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_LOAD = 4'b0010, ST_SHIFT = 4'b0100, ST_GAP = 4'b1000
    } sfcs_st_t;
    typedef enum logic [4:0] {
        PH_PRE = 5'b00001, PH_WREN = 5'b00010, PH_WEL = 5'b00100,
        PH_MAIN = 5'b01000, PH_POST = 5'b10000
    } sfcs_ph_t;
    typedef struct packed {
        logic        valid;
        sfcs_op_t    op;
        logic [23:0] addr;
        logic [15:0] len;
    } sfcs_req_t;
    typedef struct packed {
        logic        valid;
        logic        format;
        logic        secure;
        logic [24:0] size;
    } sfcs_fs_req_t;
    typedef struct packed {
        logic        ack;
        logic        ok;
        logic [23:0] base;
    } sfcs_fs_resp_t;
endpackage

// File: src/sfcs_top.sv
`timescale 1ns/10ps
// Functional notes
// - Identify: send 0x9F, clock in three identification bytes.
// - Status read: send 0x05, clock in exactly one byte.
// - Status bit 0 is busy, bit 1 is write-enable latch.
// - Write enable: send 0x06, re-read status until latch set.
// - Chip erase: send 0xC7, poll status until busy clears.
// - Read: send 0x03, 24-bit address, then 1 to 65535 bytes.
// - Page program: 0x02, 24-bit address, then 1 to 255 bytes.
// - Sector erase: 0x20, 24-bit address, poll until busy clears.
// - Erase sectors are always taken as 4K bytes.
// - Parameter table of the flash can be read.
// - File store always starts at flash address zero.
// - File store size is set by a format command.
// - Files take whole 4KB blocks, at least one.
// - Secure files take twice their size, at least 8KB.
// - At most 128 files; further creation is refused.
// - Files larger than 16MB are refused.
module sfcs_top (
    // Clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst,
    // Flash command request
    input  wire sfcs_pkg::sfcs_req_t     req,
    output logic                         req_ready,
    output logic                         done,
    output logic                         err,
    output logic [7:0]                   status,
    // Program data
    input  wire logic [7:0]              wr_data,
    input  wire logic                    wr_valid,
    output logic                         wr_ready,
    // Read data
    output logic [7:0]                   rd_data,
    output logic                         rd_valid,
    // File store
    input  wire sfcs_pkg::sfcs_fs_req_t  fs_req,
    output sfcs_pkg::sfcs_fs_resp_t      fs_resp,
    output logic [7:0]                   file_count,
    // Flash link
    output logic                         flash_sclk,
    output logic                         flash_cs_n,
    output logic                         flash_mosi,
    input  wire logic                    flash_miso
);
    sfcs_pkg::sfcs_st_t st_q;
    sfcs_pkg::sfcs_ph_t ph_q;
    sfcs_pkg::sfcs_ph_t go_ph;
    sfcs_pkg::sfcs_ph_t nxt_ph;
    sfcs_pkg::sfcs_op_t op_q;
    sfcs_pkg::sfcs_op_t go_op;
    logic        fin;
    logic [3:0]  div_q;
    logic        tick_q;
    logic        miso_s1_q;
    logic        miso_s2_q;
    logic [23:0] addr_q;
    logic [15:0] len_q;
    logic [7:0]  fop_q;
    logic [2:0]  fhdr_q;
    logic [15:0] fnd_q;
    logic [16:0] idx_q;
    logic [16:0] fend;
    logic [7:0]  sh_q;
    logic [2:0]  bit_q;
    logic        need_wr;
    logic        last_byte;
    logic [13:0] total_q;
    logic [13:0] used_q;
    logic [13:0] fs_blk;

    function automatic logic is_write(sfcs_pkg::sfcs_op_t op);
        is_write = (op == sfcs_pkg::OP_PP) || (op == sfcs_pkg::OP_SE) || (op == sfcs_pkg::OP_CE);
    endfunction

    function automatic logic len_bad(sfcs_pkg::sfcs_op_t op, logic [15:0] len);
        len_bad = ((op == sfcs_pkg::OP_RD || op == sfcs_pkg::OP_PARAM) && len == 16'h0000)
            || (op == sfcs_pkg::OP_PP && (len == 16'h0000 || len > sfcs_pkg::PP_MAX));
    endfunction

    function automatic logic [7:0] f_opc(sfcs_pkg::sfcs_ph_t ph, sfcs_pkg::sfcs_op_t op);
        f_opc = sfcs_pkg::OPC_STAT;
        if (ph == sfcs_pkg::PH_WREN) begin
            f_opc = sfcs_pkg::OPC_WREN;
        end else if (ph == sfcs_pkg::PH_MAIN) begin
            case (op)
                sfcs_pkg::OP_ID:    f_opc = sfcs_pkg::OPC_ID;
                sfcs_pkg::OP_RD:    f_opc = sfcs_pkg::OPC_RD;
                sfcs_pkg::OP_PARAM: f_opc = sfcs_pkg::OPC_PARAM;
                sfcs_pkg::OP_PP:    f_opc = sfcs_pkg::OPC_PP;
                sfcs_pkg::OP_SE:    f_opc = sfcs_pkg::OPC_SE;
                sfcs_pkg::OP_CE:    f_opc = sfcs_pkg::OPC_CE;
                default:            f_opc = sfcs_pkg::OPC_STAT;
            endcase
        end
    endfunction

    function automatic logic [2:0] f_hdr(sfcs_pkg::sfcs_ph_t ph, sfcs_pkg::sfcs_op_t op);
        f_hdr = sfcs_pkg::HDR_OPC;
        if (ph == sfcs_pkg::PH_MAIN) begin
            if (op == sfcs_pkg::OP_PARAM) begin
                f_hdr = sfcs_pkg::HDR_PARAM;
            end else if (op == sfcs_pkg::OP_RD || op == sfcs_pkg::OP_PP || op == sfcs_pkg::OP_SE) begin
                f_hdr = sfcs_pkg::HDR_ADDR;
            end
        end
    endfunction

    function automatic logic [15:0] f_nd(sfcs_pkg::sfcs_ph_t ph, sfcs_pkg::sfcs_op_t op, logic [15:0] len);
        f_nd = sfcs_pkg::STAT_LEN;
        if (ph == sfcs_pkg::PH_WREN) begin
            f_nd = 16'h0000;
        end else if (ph == sfcs_pkg::PH_MAIN) begin
            case (op)
                sfcs_pkg::OP_ID:   f_nd = sfcs_pkg::ID_LEN;
                sfcs_pkg::OP_STAT: f_nd = sfcs_pkg::STAT_LEN;
                sfcs_pkg::OP_SE:   f_nd = 16'h0000;
                sfcs_pkg::OP_CE:   f_nd = 16'h0000;
                default:           f_nd = len;
            endcase
        end
    endfunction

    function automatic logic [7:0] f_byte(logic [7:0] opc, logic [23:0] addr, logic [16:0] idx);
        case (idx)
            17'h00000: f_byte = opc;
            17'h00001: f_byte = addr[23:16];
            17'h00002: f_byte = addr[15:8];
            17'h00003: f_byte = addr[7:0];
            default:   f_byte = 8'h00;
        endcase
    endfunction

    // Half-period tick of the flash clock
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            div_q  <= 4'h0;
            tick_q <= 1'b0;
        end else if (div_q == 4'(sfcs_pkg::SCK_HALF_CYC - 1)) begin
            div_q  <= 4'h0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 4'h1;
            tick_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            miso_s1_q <= 1'b0;
            miso_s2_q <= 1'b0;
        end else begin
            miso_s1_q <= flash_miso;
            miso_s2_q <= miso_s1_q;
        end
    end

    // Next phase after a frame
    always_comb begin
        nxt_ph = ph_q;
        fin    = 1'b0;
        unique case (ph_q)
            sfcs_pkg::PH_PRE:  nxt_ph = status[sfcs_pkg::ST_BUSY] ? sfcs_pkg::PH_PRE
                : (is_write(op_q) ? sfcs_pkg::PH_WREN : sfcs_pkg::PH_MAIN);
            sfcs_pkg::PH_WREN: nxt_ph = sfcs_pkg::PH_WEL;
            sfcs_pkg::PH_WEL:  nxt_ph = status[sfcs_pkg::ST_WEL] ? sfcs_pkg::PH_MAIN : sfcs_pkg::PH_WEL;
            sfcs_pkg::PH_MAIN: begin
                nxt_ph = sfcs_pkg::PH_POST;
                fin    = !is_write(op_q);
            end
            sfcs_pkg::PH_POST: fin = !status[sfcs_pkg::ST_BUSY];
        endcase
    end

    assign go_ph     = (st_q == sfcs_pkg::ST_IDLE) ? sfcs_pkg::PH_PRE : nxt_ph;
    assign go_op     = (st_q == sfcs_pkg::ST_IDLE) ? req.op : op_q;
    assign fend      = 17'(fhdr_q) + 17'(fnd_q);
    assign last_byte = (idx_q + 17'h00001) == fend;
    assign need_wr   = ph_q == sfcs_pkg::PH_MAIN && op_q == sfcs_pkg::OP_PP && idx_q >= 17'(fhdr_q);

    // Command sequencer and byte shifter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_q       <= sfcs_pkg::ST_IDLE;
            ph_q       <= sfcs_pkg::PH_PRE;
            op_q       <= sfcs_pkg::OP_ID;
            addr_q     <= 24'h000000;
            len_q      <= 16'h0000;
            fop_q      <= 8'h00;
            fhdr_q     <= 3'h0;
            fnd_q      <= 16'h0000;
            idx_q      <= 17'h00000;
            sh_q       <= 8'h00;
            bit_q      <= 3'h0;
            req_ready  <= 1'b1;
            done       <= 1'b0;
            err        <= 1'b0;
            status     <= 8'h00;
            wr_ready   <= 1'b0;
            rd_data    <= 8'h00;
            rd_valid   <= 1'b0;
            flash_sclk <= 1'b0;
            flash_cs_n <= 1'b1;
            flash_mosi <= 1'b0;
        end else begin
            done     <= 1'b0;
            rd_valid <= 1'b0;
            unique case (st_q)
                sfcs_pkg::ST_IDLE: begin
                    if (req.valid && req_ready) begin
                        if (len_bad(req.op, req.len)) begin
                            done <= 1'b1;
                            err  <= 1'b1;
                        end else begin
                            req_ready <= 1'b0;
                            err       <= 1'b0;
                            op_q      <= req.op;
                            addr_q    <= (req.op == sfcs_pkg::OP_SE) ? (req.addr & sfcs_pkg::SECT_MASK) : req.addr;
                            len_q     <= req.len;
                            ph_q      <= go_ph;
                            fop_q     <= f_opc(go_ph, go_op);
                            fhdr_q    <= f_hdr(go_ph, go_op);
                            fnd_q     <= f_nd(go_ph, go_op, req.len);
                            idx_q     <= 17'h00000;
                            st_q      <= sfcs_pkg::ST_LOAD;
                        end
                    end
                end
                sfcs_pkg::ST_LOAD: begin
                    flash_cs_n <= 1'b0;
                    bit_q      <= 3'h0;
                    if (need_wr) begin
                        if (wr_ready && wr_valid) begin
                            wr_ready   <= 1'b0;
                            sh_q       <= wr_data;
                            flash_mosi <= wr_data[7];
                            st_q       <= sfcs_pkg::ST_SHIFT;
                        end else begin
                            wr_ready <= 1'b1;
                        end
                    end else begin
                        sh_q       <= f_byte(fop_q, addr_q, idx_q);
                        flash_mosi <= f_byte(fop_q, addr_q, idx_q)[7];
                        st_q       <= sfcs_pkg::ST_SHIFT;
                    end
                end
                sfcs_pkg::ST_SHIFT: begin
                    if (tick_q && !flash_sclk) begin
                        flash_sclk <= 1'b1;
                        sh_q       <= {sh_q[6:0], miso_s2_q};
                    end else if (tick_q) begin
                        flash_sclk <= 1'b0;
                        if (bit_q == 3'h7) begin
                            idx_q <= idx_q + 17'h00001;
                            if (idx_q >= 17'(fhdr_q)) begin
                                if (ph_q != sfcs_pkg::PH_MAIN || op_q == sfcs_pkg::OP_STAT) begin
                                    status <= sh_q;
                                end
                                if (ph_q == sfcs_pkg::PH_MAIN && !is_write(op_q)) begin
                                    rd_data  <= sh_q;
                                    rd_valid <= 1'b1;
                                end
                            end
                            if (last_byte) begin
                                flash_cs_n <= 1'b1;
                                st_q       <= sfcs_pkg::ST_GAP;
                            end else begin
                                st_q <= sfcs_pkg::ST_LOAD;
                            end
                        end else begin
                            bit_q      <= bit_q + 3'h1;
                            flash_mosi <= sh_q[7];
                        end
                    end
                end
                sfcs_pkg::ST_GAP: begin
                    if (tick_q && fin) begin
                        done      <= 1'b1;
                        req_ready <= 1'b1;
                        st_q      <= sfcs_pkg::ST_IDLE;
                    end else if (tick_q) begin
                        ph_q   <= go_ph;
                        fop_q  <= f_opc(go_ph, go_op);
                        fhdr_q <= f_hdr(go_ph, go_op);
                        fnd_q  <= f_nd(go_ph, go_op, len_q);
                        idx_q  <= 17'h00000;
                        st_q   <= sfcs_pkg::ST_LOAD;
                    end
                end
            endcase
        end
    end

    // File store allocation
    always_comb begin
        fs_blk = 14'(({1'b0, fs_req.size} + sfcs_pkg::BLK_ROUND) >> sfcs_pkg::BLK_LOG2);
        if (fs_blk == 14'h0000 && !fs_req.format) begin
            fs_blk = 14'h0001;
        end
        if (fs_req.secure && !fs_req.format) begin
            fs_blk = 14'(fs_blk << 1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            total_q    <= 14'h0000;
            used_q     <= 14'h0000;
            file_count <= 8'h00;
            fs_resp    <= '0;
        end else begin
            fs_resp.ack <= fs_req.valid;
            fs_resp.ok  <= 1'b0;
            if (fs_req.valid && fs_req.format) begin
                if (fs_req.size <= sfcs_pkg::FILE_MAX) begin
                    total_q      <= fs_blk;
                    used_q       <= 14'h0000;
                    file_count   <= 8'h00;
                    fs_resp.ok   <= 1'b1;
                    fs_resp.base <= sfcs_pkg::STORE_BASE;
                end
            end else if (fs_req.valid) begin
                if (file_count != sfcs_pkg::FILES_MAX
                    && fs_req.size <= sfcs_pkg::FILE_MAX
                    && 15'(used_q) + 15'(fs_blk) <= 15'(total_q)) begin
                    used_q       <= used_q + fs_blk;
                    file_count   <= file_count + 8'h01;
                    fs_resp.ok   <= 1'b1;
                    fs_resp.base <= sfcs_pkg::STORE_BASE + 24'({used_q, 12'h000});
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_wel_ok;
        ph_q == sfcs_pkg::PH_WEL && st_q == sfcs_pkg::ST_GAP && tick_q && status[sfcs_pkg::ST_WEL];
    endsequence

    a_wel_to_cmd: assert property (s_wel_ok |=> ph_q == sfcs_pkg::PH_MAIN && st_q == sfcs_pkg::ST_LOAD)
        else $error("write enable not followed by command");
    a_write_after_wel: assert property ($rose(ph_q == sfcs_pkg::PH_MAIN) && is_write(op_q)
        |-> $past(ph_q) == sfcs_pkg::PH_WEL && $past(status[sfcs_pkg::ST_WEL]))
        else $error("write command without latch set");
    a_no_start_busy: assert property ($fell(ph_q == sfcs_pkg::PH_PRE) |-> !$past(status[sfcs_pkg::ST_BUSY]))
        else $error("command started while busy");
    a_erase_polled: assert property (done && !err && is_write(op_q)
        |-> ph_q == sfcs_pkg::PH_POST && !status[sfcs_pkg::ST_BUSY])
        else $error("write finished without busy clear");
    a_cs_frame_hold: assert property (st_q == sfcs_pkg::ST_SHIFT |-> !flash_cs_n)
        else $error("chip select released mid byte");
    a_msb_first: assert property ($rose(st_q == sfcs_pkg::ST_SHIFT) |-> flash_mosi == sh_q[7])
        else $error("first bit is not msb");
    a_id_frame: assert property (ph_q == sfcs_pkg::PH_MAIN && op_q == sfcs_pkg::OP_ID
        |-> fop_q == sfcs_pkg::OPC_ID && fnd_q == sfcs_pkg::ID_LEN)
        else $error("bad identify frame");
    a_status_frame: assert property (st_q != sfcs_pkg::ST_IDLE && (ph_q == sfcs_pkg::PH_PRE || ph_q == sfcs_pkg::PH_POST)
        |-> fop_q == sfcs_pkg::OPC_STAT && fnd_q == sfcs_pkg::STAT_LEN)
        else $error("bad status frame");
    a_prog_len: assert property (ph_q == sfcs_pkg::PH_MAIN && op_q == sfcs_pkg::OP_PP
        |-> fnd_q != 16'h0000 && fnd_q <= sfcs_pkg::PP_MAX && fhdr_q == sfcs_pkg::HDR_ADDR)
        else $error("program length out of range");
    a_sector_align: assert property (ph_q == sfcs_pkg::PH_MAIN && op_q == sfcs_pkg::OP_SE
        |-> addr_q[11:0] == 12'h000 && fop_q == sfcs_pkg::OPC_SE)
        else $error("sector address not aligned");
    a_file_limit: assert property (fs_req.valid && !fs_req.format && file_count == sfcs_pkg::FILES_MAX
        |=> fs_resp.ack && !fs_resp.ok)
        else $error("file beyond limit accepted");
    a_file_size: assert property (fs_req.valid && fs_req.size > sfcs_pkg::FILE_MAX
        |=> fs_resp.ack && !fs_resp.ok)
        else $error("oversize file accepted");
endmodule

// File: tb/sfcs_flash_model.sv
`timescale 1ns/10ps
module sfcs_flash_model #(
    parameter int          BUSY_POLLS = 3,
    parameter int          WEL_POLLS  = 1,
    // Arbitrary identification value
    parameter logic [23:0] ID_CODE    = 24'h3ca511
) (
    // Link
    input  wire logic        flash_sclk,
    input  wire logic        flash_cs_n,
    input  wire logic        flash_mosi,
    output logic             flash_miso = 1'b0,
    // Observation
    output logic [7:0]       last_op    = 8'h00,
    output logic [23:0]      last_addr  = 24'h000000,
    output logic [8:0]       pp_n       = 9'h000,
    output logic [7:0]       pp_first   = 8'h00,
    output logic [7:0]       pp_last    = 8'h00,
    output logic [7:0]       viol       = 8'h00
);
    logic [7:0]  sh        = 8'h00;
    logic [7:0]  op        = 8'h00;
    logic [7:0]  outb      = 8'h00;
    logic [23:0] addr      = 24'h000000;
    logic        busy_at   = 1'b0;
    int          bits      = 0;
    int          idx       = 0;
    int          busy_left = 0;
    int          wel_wait  = -1;

    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16];
    endfunction

    function automatic logic [7:0] resp();
        case (op)
            8'h9f: return 8'(ID_CODE >> (8 * (3 - idx)));
            8'h05: return {6'h00, wel_wait == 0, busy_left > 0};
            8'h03: return pat(addr + 24'(idx - 4));
            8'h5a: return pat(addr + 24'(idx - 5));
            default: return ~flash_miso;
        endcase
    endfunction

    always @(negedge flash_cs_n) begin
        bits = 0;
        idx = 0;
        busy_at = busy_left > 0;
    end

    // Mode 0: take MOSI on rising clock, MSB first
    always @(posedge flash_sclk) begin
        if (!flash_cs_n) begin
            sh = {sh[6:0], flash_mosi};
            bits++;
            if (bits % 8 == 0) begin
                if (idx == 0) begin
                    op = sh;
                    pp_n = (sh == 8'h02) ? 9'h000 : pp_n;
                end
                else if (idx <= 3) addr = {addr[15:0], sh};
                else if (op == 8'h02) begin
                    pp_first = (pp_n == 0) ? sh : pp_first;
                    pp_last = sh;
                    pp_n++;
                end
                idx++;
            end
        end
    end

    always @(negedge flash_sclk) begin
        if (!flash_cs_n) begin
            if (bits % 8 == 0) outb = resp();
            flash_miso = outb[7 - bits % 8];
        end
    end

    // Frame end: update latch and busy, release MISO to a changed level
    always @(posedge flash_cs_n) begin
        if (bits >= 8) begin
            // Status polls do not hide the command that they follow
            if (op != 8'h05) last_op = op;
            if (busy_at && op != 8'h05) viol++;
            case (op)
                8'h06: wel_wait = WEL_POLLS;
                8'h05: begin
                    wel_wait = (wel_wait > 0) ? wel_wait - 1 : wel_wait;
                    busy_left = (busy_left > 0) ? busy_left - 1 : 0;
                end
                8'h02, 8'h20, 8'hc7: begin
                    if (wel_wait != 0) viol++;
                    wel_wait = -1;
                    busy_left = BUSY_POLLS;
                    last_addr = addr;
                end
                default: last_addr = addr;
            endcase
        end
        flash_miso = ~flash_miso;
    end
endmodule

// File: tb/sfcs_top_tb.sv
`timescale 1ns/10ps
module sfcs_top_tb;
    // Arbitrary identification value
    localparam logic [23:0]  ID_VAL = 24'h3ca511;
    logic                    core_clk, rst, req_ready, done, err, wr_valid, wr_ready, rd_valid;
    logic                    flash_sclk, flash_cs_n, flash_mosi, flash_miso;
    logic [7:0]              status, wr_data, rd_data, file_count, last_op, pp_first, pp_last, viol;
    logic [23:0]             last_addr;
    logic [8:0]              pp_n;
    sfcs_pkg::sfcs_req_t     req;
    sfcs_pkg::sfcs_fs_req_t  fs_req;
    sfcs_pkg::sfcs_fs_resp_t fs_resp;
    logic [7:0]              rx[$];
    int                      miscompares, checks;

    sfcs_top dut (
        .core_clk(core_clk), .rst(rst), .req(req), .req_ready(req_ready), .done(done), .err(err),
        .status(status), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
        .rd_valid(rd_valid), .fs_req(fs_req), .fs_resp(fs_resp), .file_count(file_count),
        .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi), .flash_miso(flash_miso)
    );
    sfcs_flash_model #(.ID_CODE(ID_VAL)) fl (
        .flash_sclk(flash_sclk), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi), .flash_miso(flash_miso),
        .last_op(last_op), .last_addr(last_addr), .pp_n(pp_n), .pp_first(pp_first), .pp_last(pp_last), .viol(viol)
    );

    function automatic logic [7:0] pat(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16];
    endfunction

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // One command; feeds program bytes, gathers read bytes until done
    task cmd(input sfcs_pkg::sfcs_op_t op, input logic [23:0] a, input logic [15:0] n, input logic e);
        int   k;
        int   idx;
        logic pend;
        rx.delete();
        idx = 0;
        pend = 1'b0;
        @(negedge core_clk);
        req = '{1'b1, op, a, n};
        for (k = 0; k < 40000; k++) begin
            // Refused requests pulse done on the same edge that takes them
            @(negedge core_clk);
            req.valid = 1'b0;
            idx += int'(pend);
            if (rd_valid === 1'b1) rx.push_back(rd_data);
            if (done === 1'b1) break;
            wr_valid = (op == sfcs_pkg::OP_PP) && (idx < int'(n));
            wr_data = 8'h1e + 8'(idx);
            pend = wr_valid && (wr_ready === 1'b1);
        end
        wr_valid = 1'b0;
        chk(done, 1'b1);
        chk(err, e);
    endtask

    task t_id;
        int i;
        cmd(sfcs_pkg::OP_ID, 24'h000000, 16'h0000, 1'b0);
        chk(rx.size(), 3);
        for (i = 0; i < 3; i++) chk(rx[i], 8'(ID_VAL >> (16 - 8 * i)));
        chk(last_op, 8'h9f);
    endtask

    task t_stat;
        cmd(sfcs_pkg::OP_STAT, 24'h000000, 16'h0000, 1'b0);
        chk(rx.size(), 1);
        chk(rx[0], 8'h00);
        chk(status, 8'h00);
        chk(last_op, 8'h9f);
    endtask

    task t_rd(input sfcs_pkg::sfcs_op_t op, input logic [23:0] a, input logic [7:0] opc);
        int i;
        cmd(op, a, 16'h0004, 1'b0);
        chk(rx.size(), 4);
        for (i = 0; i < 4; i++) chk(rx[i], pat(a + 24'(i)));
        chk(last_op, opc);
        chk(last_addr, a);
    endtask

    task t_prog;
        cmd(sfcs_pkg::OP_PP, 24'h000100, 16'h0003, 1'b0);
        chk(pp_n, 3);
        chk(pp_first, 8'h1e);
        chk(pp_last, 8'h20);
        chk(last_addr, 24'h000100);
        chk(viol, 8'h00);
        chk(status[1:0], 2'b00);
        cmd(sfcs_pkg::OP_PP, 24'h000200, 16'h0000, 1'b1);
        cmd(sfcs_pkg::OP_PP, 24'h000200, 16'h0100, 1'b1);
        cmd(sfcs_pkg::OP_RD, 24'h000200, 16'h0000, 1'b1);
        chk(last_op, 8'h02);
        cmd(sfcs_pkg::OP_PP, 24'h000300, 16'h00ff, 1'b0);
        chk(pp_n, 255);
        chk(pp_last, 8'h1c);
    endtask

    task t_erase;
        cmd(sfcs_pkg::OP_SE, 24'h123abc, 16'h0000, 1'b0);
        chk(last_addr, 24'h123000);
        chk(last_op, 8'h20);
        cmd(sfcs_pkg::OP_CE, 24'h000000, 16'h0000, 1'b0);
        chk(last_op, 8'hc7);
        chk(status[0], 1'b0);
        chk(viol, 8'h00);
        chk(flash_cs_n, 1'b1);
    endtask

    task fs(input logic f, input logic s, input logic [24:0] sz, input logic ok, input logic [23:0] b);
        @(negedge core_clk);
        fs_req = '{1'b1, f, s, sz};
        @(negedge core_clk);
        fs_req.valid = 1'b0;
        chk(fs_resp.ack, 1'b1);
        chk(fs_resp.ok, ok);
        if (ok && !f) chk(fs_resp.base, b);
    endtask

    task t_store;
        fs(1'b0, 1'b0, 25'h0000001, 1'b0, 24'h000000);
        fs(1'b1, 1'b0, 25'h1000001, 1'b0, 24'h000000);
        fs(1'b1, 1'b0, 25'h0010000, 1'b1, 24'h000000);
        fs(1'b0, 1'b0, 25'h0000001, 1'b1, 24'h000000);
        fs(1'b0, 1'b1, 25'h0000001, 1'b1, 24'h001000);
        fs(1'b0, 1'b0, 25'h0001001, 1'b1, 24'h003000);
        fs(1'b0, 1'b0, 25'h1000001, 1'b0, 24'h000000);
        fs(1'b0, 1'b0, 25'h000c000, 1'b0, 24'h000000);
        fs(1'b0, 1'b0, 25'h000a000, 1'b1, 24'h005000);
        chk(file_count, 8'h04);
    endtask

    task t_limit;
        int i;
        fs(1'b1, 1'b0, 25'h1000000, 1'b1, 24'h000000);
        for (i = 0; i < 128; i++) fs(1'b0, 1'b0, 25'h0000001, 1'b1, 24'(i * 4096));
        chk(file_count, 8'h80);
        fs(1'b0, 1'b0, 25'h0000001, 1'b0, 24'h000000);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        #400us;
        miscompares++;
        conclude;
    end

    initial begin
        miscompares = 0;
        checks = 0;
        req = '0;
        fs_req = '0;
        wr_valid = 1'b0;
        wr_data = 8'h00;
        rst = 1'b1;
        repeat (20) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        t_id;
        t_stat;
        t_rd(sfcs_pkg::OP_RD, 24'h123456, 8'h03);
        t_rd(sfcs_pkg::OP_PARAM, 24'h000010, 8'h5a);
        t_prog;
        t_erase;
        t_store;
        t_limit;
        conclude;
    end
endmodule
